// ==== common/spi_ctl_regs.svh ====
/*
 * register map, field positions, reset values and timing counts of the
 * serial control block.
 * assumes a byte-addressed 8-bit register port with 32-bit data words.
 */
`ifndef SPI_CTL_REGS_SVH
`define SPI_CTL_REGS_SVH

// register offsets
`define SCS_OFFSET      8'h00
`define DIV_OFFSET      8'h04

// reset values as seen by software
`define SCS_RESET       32'h0500_3004
`define DIV_RESET       32'h0000_0000

// bits that a plain write stores
`define SCS_WMASK       32'h00EE_FCFF
`define DIV_WMASK       32'h00FF_00FF
// bits held in flops (writable ones plus the sticky flag)
`define SCS_STORE_MASK  32'h00EF_FCFF

// control and status fields
`define FLAGS_MSB       27
`define FLAGS_LSB       24
`define BIT_CLOCK_PATTERN_WORD      23
`define BIT_DUAL        22
`define BIT_QUEUE       21
`define BIT_SWAP        19
`define BIT_SLAVE       18
`define BIT_IE          17
`define BIT_IF          16
`define GAP_MSB         15
`define GAP_LSB         12
`define BIT_SCLK_IDLE_POLARITY        11
`define BIT_LSB         10
`define LEN_MSB         7
`define LEN_LSB         3
`define BIT_TXNEG       2
`define BIT_RXNEG       1
`define BIT_TRIG        0

// divisor fields
`define DIV2_MSB        23
`define DIV2_LSB        16
`define DIV_MSB         7
`define DIV_LSB         0

// timing counts in serial clock half periods
`define VAR_EXTRA_HALVES 10'd12
`define BYTE_HALVES_MASK 4'hF

`endif

// ==== common/spi_ctl_pkg.sv ====
/*
 * types shared by the serial control block and its divider.
 * assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package spi_ctl_pkg;

    // engine sequencing
    typedef enum logic [1:0] {
        ENG_IDLE  = 2'b00,
        ENG_SHIFT = 2'b01,
        ENG_GAP   = 2'b10
    } eng_state_t;

    // flags mirrored from the queue status
    typedef struct packed {
        logic tx_full;
        logic tx_empty;
        logic rx_full;
        logic rx_empty;
    } queue_flags_t;

    // serial pins as seen from the device
    typedef struct packed {
        logic       sclk;
        logic       select_active;
        logic [1:0] din;
    } serial_in_t;

    typedef struct packed {
        logic       sclk;
        logic       sclk_oe;
        logic [1:0] dout;
    } serial_out_t;

    // whole state of the controller
    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] div;
        logic [31:0] rdata;
        eng_state_t  eng;
        logic        mid_word;
        logic        sclk;
        logic        slv_clk;
        logic [1:0]  dout;
        logic [31:0] tx0;
        logic [31:0] tx1;
        logic [31:0] rx0;
        logic [31:0] rx1;
        logic [5:0]  tx_k;
        logic [5:0]  rx_cnt;
        logic [6:0]  half_cnt;
        logic [9:0]  wait_cnt;
    } ctl_state_t;

    // whole state of the divider
    typedef struct packed {
        logic [7:0] cnt;
    } pacer_state_t;

endpackage

`default_nettype wire

// ==== rtl/half_period_pacer.sv ====
/*
 * engine clock divider: one tick per serial clock half period.
 * assumes engine_src_edge pulses once per edge of the engine source clock,
 * synchronous to sys_clk.
 */
`default_nettype none

module half_period_pacer (
    input  wire logic       sys_clk,          // system clock
    input  wire logic       rst,              // sync reset, high
    input  wire logic       clk_en,           // freezes state when low
    input  wire logic       run,              // count only while set
    input  wire logic       compat,           // 1: count source edges
    input  wire logic       engine_src_edge,  // source clock edge pulse
    input  wire logic [7:0] divisor,          // engine divisor field
    output logic            tick              // half period elapsed
);
    import spi_ctl_pkg::*;

    pacer_state_t st;
    pacer_state_t next_st;
    logic         ev;

    ////////////////////////////////////////////////////////////////////////
    // d+1 events per half period: sys mode gives 2(d+1) sys cycles a
    // period, source mode gives d+1 source periods a period
    assign ev   = compat ? engine_src_edge : 1'b1;
    assign tick = clk_en && run && ev && (st.cnt == divisor);

    always_comb begin
        next_st = st;
        if (!run) begin
            next_st.cnt = 8'h00;
        end else if (ev) begin
            next_st.cnt = tick ? 8'h00 : 8'(st.cnt + 8'h01);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking pcb @(posedge sys_clk); endclocking
    default disable iff (rst);

    tick_spacing_a: assert property (
        tick && !compat && divisor != 8'h00 |=> !tick)
        else $error("divider ticks on adjacent cycles");

endmodule

`default_nettype wire

// ==== rtl/spi_control_and_clock_divider.sv ====
/*
 * control, status and divider logic of a serial peripheral controller,
 * with its word shifter, inter-word and byte gaps and unit flag.
 * assumes the transmit queue, data registers, dma engine and slave select
 * logic sit outside; serial inputs are synchronous to sys_clk.
 */
`include "spi_ctl_regs.svh"
`default_nettype none

//  Contract
// - bits 27..24 read queue full/empty flags, mirrored, read only.
// - varying clock on in master: clock shaped by pattern and both divisors.
// - dual mode shifts two lanes from/to words one and zero.
// - queue mode master: queue write sets trigger, empty queue clears it.
// - byte swap adds gap between bytes for 16/24/32-bit words only.
// - unit flag sets per word, write one clears, interrupt needs enable.
// - master word gap is gap count plus half a serial period.
// - varying clock with queue data adds six more periods to gap.
// - serial clock idles at the polarity bit.
// - low-first sends bit zero first, else top bit of word length.
// - length code gives bits per word, zero means thirty-two.
// - output data changes on falling edge when drive bit set.
// - input data sampled on falling edge when sample bit set.
// - writing trigger starts master transfer or arms slave.
// - without queue, trigger stays one while busy, clears when done.
// - queue mode owns trigger; slave reads one, master shows busy.
// - without queue, trigger clears only after dma finishes.
// - second clock is engine clock over twice second divisor plus one.
// - engine clock divides system or source clock by divisor field.
module spi_control_and_clock_divider (
    input  wire logic                      sys_clk,        // system clock
    input  wire logic                      rst,            // sync reset
    input  wire logic                      clk_en,         // freeze when low
    input  wire logic [7:0]                reg_addr,       // byte address
    input  wire logic [31:0]               reg_wdata,      // write data
    input  wire logic                      reg_wr,         // write strobe
    input  wire logic                      reg_rd,         // read strobe
    output logic [31:0]                    reg_rdata,      // read data
    input  wire spi_ctl_pkg::queue_flags_t queue_flags,    // queue status
    input  wire logic                      queue_write,    // tx queue write
    input  wire logic                      dma_active,     // dma running
    input  wire logic                      divider_compat_select, // src sel
    input  wire logic                      engine_src_edge, // src edge
    input  wire logic [31:0]               clock_pattern_word, // clk shape
    input  wire logic [31:0]               transmit_word_zero, // lane 0
    input  wire logic [31:0]               transmit_word_one,  // lane 1
    output logic [31:0]                    receive_word_zero,  // lane 0
    output logic [31:0]                    receive_word_one,   // lane 1
    output logic                           word_taken,     // tx word used
    output logic                           word_stored,    // rx word done
    input  wire spi_ctl_pkg::serial_in_t   serial_in,      // serial inputs
    output var spi_ctl_pkg::serial_out_t   serial_out,     // serial outputs
    output logic                           unit_irq        // unit interrupt
);
    import spi_ctl_pkg::*;

    ctl_state_t  st;
    ctl_state_t  next_st;

    logic        var_en;
    logic        dual;
    logic        queue_mode;
    logic        slave;
    logic        sclk_idle_polarity;
    logic        lsb_first;
    logic        txneg;
    logic        rxneg;
    logic [3:0]  gap_count;
    logic [5:0]  bits_n;
    logic [7:0]  div1;
    logic [7:0]  div2;
    logic        trig_view;
    logic [31:0] ctl_view;
    logic        base_tick;
    logic [9:0]  need;
    logic [9:0]  gap_halves;
    logic        master_edge;
    logic        slave_edge;
    logic        edge_now;
    logic        edge_rise;
    logic        sample_now;
    logic        drive_now;
    logic        last_half;
    logic        done;
    logic        swap_ok;
    logic        byte_gap;
    logic        more;
    logic        start;
    logic        scs_wr;
    logic        sw_trig_set;
    logic        load;
    logic [4:0]  rx_idx;
    logic [4:0]  tx_idx;
    logic [4:0]  first_idx;

    ////////////////////////////////////////////////////////////////////////
    // bit position of the k-th bit on the wire
    function automatic logic [4:0] bit_index(
        input logic [5:0] k,
        input logic [5:0] n,
        input logic       low_first
    );
        return low_first ? k[4:0] : 5'(n - 6'd1 - k);
    endfunction

    // configuration fields
    assign var_en     = st.ctl[`BIT_CLOCK_PATTERN_WORD] && !slave;
    assign dual       = st.ctl[`BIT_DUAL];
    assign queue_mode = st.ctl[`BIT_QUEUE];
    assign slave      = st.ctl[`BIT_SLAVE];
    assign sclk_idle_polarity       = st.ctl[`BIT_SCLK_IDLE_POLARITY];
    assign lsb_first  = st.ctl[`BIT_LSB];
    assign txneg      = st.ctl[`BIT_TXNEG];
    assign rxneg      = st.ctl[`BIT_RXNEG];
    assign gap_count  = st.ctl[`GAP_MSB:`GAP_LSB];
    assign div1       = st.div[`DIV_MSB:`DIV_LSB];
    assign div2       = st.div[`DIV2_MSB:`DIV2_LSB];
    // code zero means a full 32-bit word
    assign bits_n = (st.ctl[`LEN_MSB:`LEN_LSB] == 5'h00) ? 6'd32 :
                    {1'b0, st.ctl[`LEN_MSB:`LEN_LSB]};

    // software view; slave in queue mode always reads busy
    assign trig_view = (queue_mode && slave) || st.ctl[`BIT_TRIG];
    assign ctl_view  = {4'h0, queue_flags, st.ctl[23:1], trig_view};

    ////////////////////////////////////////////////////////////////////////
    // engine clock: one tick each serial half period
    half_period_pacer pacer (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .clk_en          (clk_en),
        .run             (st.eng != ENG_IDLE && !slave),
        .compat          (divider_compat_select),
        .engine_src_edge (engine_src_edge),
        .divisor         (div1),
        .tick            (base_tick)
    );

    // a pattern bit of one stretches that half to the second clock;
    // the pattern covers 32 halves, so words of up to 16 bits fit it
    assign need = (var_en && clock_pattern_word[st.half_cnt[4:0]]) ?
                  10'((10'(div2) + 10'd1) << 1) : 10'd1;

    // gap in halves: 2g+1, plus twelve with varying clock and queued data
    assign gap_halves = 10'({gap_count, 1'b1}) +
        ((var_en && !queue_flags.tx_empty) ? `VAR_EXTRA_HALVES : 10'd0);

    // serial edges; an inactive select hides slave clock edges
    assign master_edge = !slave && st.eng == ENG_SHIFT && base_tick &&
                         (10'(st.wait_cnt + 10'd1) >= need);
    assign slave_edge  = slave && st.eng == ENG_SHIFT &&
                         serial_in.select_active &&
                         (serial_in.sclk != st.slv_clk);
    assign edge_now    = master_edge || slave_edge;
    assign edge_rise   = slave ? serial_in.sclk : !st.sclk;
    assign sample_now  = edge_now && (edge_rise != rxneg);
    assign drive_now   = edge_now && (edge_rise != txneg) &&
                         (st.rx_cnt > st.tx_k);
    assign last_half   = 7'(st.half_cnt + 7'd1) == {bits_n, 1'b0};
    assign done = slave ? (sample_now && 6'(st.rx_cnt + 6'd1) == bits_n)
                        : (master_edge && last_half);

    // byte gaps only for whole-byte words on a plain single lane
    assign swap_ok  = st.ctl[`BIT_SWAP] && !var_en && !dual &&
                      (bits_n == 6'd16 || bits_n == 6'd24 ||
                       bits_n == 6'd32);
    assign byte_gap = master_edge && swap_ok && !last_half &&
                      st.half_cnt[3:0] == `BYTE_HALVES_MASK &&
                      gap_halves != 10'd1;

    // next word comes from the queue, or from dma while it runs
    assign more  = queue_mode ? !queue_flags.tx_empty : dma_active;
    assign start = trig_view && (!queue_mode || !queue_flags.tx_empty);

    assign scs_wr      = reg_wr && reg_addr == `SCS_OFFSET;
    assign sw_trig_set = scs_wr && reg_wdata[`BIT_TRIG] && !queue_mode;

    assign rx_idx    = bit_index(st.rx_cnt, bits_n, lsb_first);
    assign tx_idx    = bit_index(6'(st.tx_k + 6'd1), bits_n, lsb_first);
    assign first_idx = bit_index(6'd0, bits_n, lsb_first);

    ////////////////////////////////////////////////////////////////////////
    // next state: register port first, engine second, so hardware sets
    // land after software clears
    always_comb begin
        next_st     = st;
        load        = 1'b0;
        word_taken  = 1'b0;
        word_stored = 1'b0;

        // register writes; reserved bits never stored
        if (scs_wr) begin
            next_st.ctl = (reg_wdata & `SCS_WMASK) |
                          (st.ctl & ~`SCS_WMASK);
            if (queue_mode) begin
                next_st.ctl[`BIT_TRIG] = st.ctl[`BIT_TRIG];
            end
            if (reg_wdata[`BIT_IF]) begin
                next_st.ctl[`BIT_IF] = 1'b0;
            end
        end
        if (reg_wr && reg_addr == `DIV_OFFSET) begin
            next_st.div = reg_wdata & `DIV_WMASK;
        end

        // read data valid in the cycle after the strobe only
        next_st.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == `SCS_OFFSET) begin
                next_st.rdata = ctl_view;
            end else if (reg_addr == `DIV_OFFSET) begin
                next_st.rdata = st.div;
            end
        end

        next_st.slv_clk = serial_in.sclk;

        unique case (st.eng)
            ENG_IDLE: begin
                next_st.sclk     = sclk_idle_polarity;
                next_st.mid_word = 1'b0;
                next_st.wait_cnt = 10'd0;
                if (start) begin
                    load = 1'b1;
                end
            end
            ENG_SHIFT: begin
                if (base_tick && !slave) begin
                    next_st.wait_cnt = master_edge ? 10'd0 :
                                       10'(st.wait_cnt + 10'd1);
                end
                if (edge_now) begin
                    next_st.half_cnt = 7'(st.half_cnt + 7'd1);
                    if (!slave) begin
                        next_st.sclk = !st.sclk;
                    end
                end
                if (sample_now) begin
                    next_st.rx0[rx_idx] = serial_in.din[0];
                    if (dual) begin
                        next_st.rx1[rx_idx] = serial_in.din[1];
                    end
                    next_st.rx_cnt = 6'(st.rx_cnt + 6'd1);
                end
                if (drive_now) begin
                    next_st.tx_k = 6'(st.tx_k + 6'd1);
                    next_st.dout = {dual && st.tx1[tx_idx],
                                    st.tx0[tx_idx]};
                end
                if (done) begin
                    next_st.ctl[`BIT_IF] = 1'b1;
                    word_stored = clk_en;
                    if (more && (slave || gap_halves == 10'd1)) begin
                        load = 1'b1;
                    end else if (more) begin
                        next_st.eng      = ENG_GAP;
                        next_st.wait_cnt = 10'd0;
                    end else begin
                        next_st.eng = ENG_IDLE;
                        if (!trig_view || !slave || !queue_mode) begin
                            if (!sw_trig_set) begin
                                next_st.ctl[`BIT_TRIG] = 1'b0;
                            end
                        end
                    end
                end else if (byte_gap) begin
                    next_st.eng      = ENG_GAP;
                    next_st.mid_word = 1'b1;
                    next_st.wait_cnt = 10'd0;
                end
            end
            ENG_GAP: begin
                // the first half of the next word supplies the last
                // half period, so the gap stops one half early
                if (base_tick) begin
                    if (10'(st.wait_cnt + 10'd2) >= gap_halves) begin
                        next_st.wait_cnt = 10'd0;
                        if (st.mid_word) begin
                            next_st.eng      = ENG_SHIFT;
                            next_st.mid_word = 1'b0;
                        end else if (more) begin
                            load = 1'b1;
                        end else begin
                            next_st.eng = ENG_IDLE;
                            if (!sw_trig_set) begin
                                next_st.ctl[`BIT_TRIG] = 1'b0;
                            end
                        end
                    end else begin
                        next_st.wait_cnt = 10'(st.wait_cnt + 10'd1);
                    end
                end
            end
            default: begin
                next_st.eng = ENG_IDLE;
            end
        endcase

        // fresh word: first bit presented before the first edge
        if (load) begin
            next_st.eng      = ENG_SHIFT;
            next_st.tx0      = transmit_word_zero;
            next_st.tx1      = dual ? transmit_word_one : 32'h0000_0000;
            next_st.tx_k     = 6'd0;
            next_st.rx_cnt   = 6'd0;
            next_st.half_cnt = 7'd0;
            next_st.wait_cnt = 10'd0;
            next_st.sclk     = sclk_idle_polarity;
            next_st.dout     = {dual && transmit_word_one[first_idx],
                                transmit_word_zero[first_idx]};
            word_taken       = clk_en;
        end

        // queue write arms the master after any clear above
        if (queue_write && queue_mode && !slave) begin
            next_st.ctl[`BIT_TRIG] = 1'b1;
        end
    end

    // state register; enable low holds everything
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st     <= '0;
            st.ctl <= `SCS_RESET & `SCS_STORE_MASK;
            st.div <= `DIV_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata          = st.rdata;
    assign receive_word_zero  = st.rx0;
    assign receive_word_one   = st.rx1;
    assign serial_out.sclk    = st.sclk;
    assign serial_out.sclk_oe = !slave;
    assign serial_out.dout    = st.dout;
    assign unit_irq = st.ctl[`BIT_IF] && st.ctl[`BIT_IE];

    ////////////////////////////////////////////////////////////////////////
    default clocking ccb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence word_to_gap;
        clk_en && st.eng == ENG_SHIFT && !slave ##1 st.eng == ENG_GAP;
    endsequence

    flags_mirror_a: assert property (
        clk_en && reg_rd && reg_addr == `SCS_OFFSET |=>
        reg_rdata[`FLAGS_MSB:`FLAGS_LSB] == $past(queue_flags))
        else $error("queue flags not mirrored");

    flag_set_a: assert property (
        clk_en && done |=> st.ctl[`BIT_IF])
        else $error("unit flag missed");

    irq_raise_a: assert property (
        clk_en && done && st.ctl[`BIT_IE] && !scs_wr |=> unit_irq)
        else $error("interrupt not raised");

    idle_level_a: assert property (
        clk_en && st.eng == ENG_IDLE |=> serial_out.sclk == $past(sclk_idle_polarity))
        else $error("clock not at idle level");

    busy_clear_a: assert property (
        clk_en && done && !queue_mode && !dma_active && !sw_trig_set
        |=> !st.ctl[`BIT_TRIG] && st.eng == ENG_IDLE)
        else $error("busy not cleared after word");

    slave_busy_a: assert property (
        clk_en && queue_mode && slave && reg_rd &&
        reg_addr == `SCS_OFFSET |=> reg_rdata[`BIT_TRIG])
        else $error("slave queue busy reads zero");

    word_bits_a: assert property (
        clk_en && done && !slave && !more |=> st.rx_cnt == $past(bits_n))
        else $error("wrong bit count in word");

    gap_quiet_a: assert property (
        word_to_gap |-> serial_out.sclk == sclk_idle_polarity)
        else $error("clock active during gap");

endmodule

`default_nettype wire

// ==== test/spi_slave_model.sv ====
/*
 * far-side serial slave: shifts a reply byte out msb first, collects
 * the byte it receives. assumes sclk idles low and is sys_clk synchronous.
 */
`default_nettype none

module spi_slave_model (
    input  wire logic       sys_clk, // system clock
    input  wire logic       sclk,    // serial clock from master
    input  wire logic       mosi,    // master data
    input  wire logic [7:0] reply,   // byte to send back
    output logic            miso,    // slave data
    output logic [7:0]      got      // byte collected
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       last = 1'b0;
    logic [2:0] n = 3'h0;

    // edges seen one cycle late, so data is long settled by then
    always @(posedge sys_clk) begin
        last <= sclk;
        if (sclk && !last)
            got <= {got[6:0], mosi};
        if (!sclk && last)
            n <= n + 3'h1;
    end
    assign miso = reply[3'h7 - n];
endmodule

`default_nettype wire

// ==== test/spi_control_and_clock_divider_tb_top.sv ====
/*
 * bench of the serial control block: registers, one master word, two dma words and a varying clock word.
 * assumes the design package and register header are compiled first.
 */
`include "spi_ctl_regs.svh"
`default_nettype none

module spi_control_and_clock_divider_tb_top;
    import spi_ctl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_q = 0;
    logic miso, done, irq, taken, dma = 0;
    logic [7:0] reg_addr = 8'h00, got, reply = 8'h5A;
    logic [31:0] reg_wdata = 0, reg_rdata, tx0 = 0, tx1 = 0, pat = 0;
    logic [31:0] rx0, rx1, r, q[$];
    queue_flags_t qf = 4'h5;
    serial_out_t so;
    int failures = 0, comparisons = 0, cyc = 0, hi = 0;
    // want: cycles from word load to word end, 16 halves of 4 at first
    int nt = 0, nd = 0, sp = 0, vs = 0, want = 64;

    spi_control_and_clock_divider dut_u (.sys_clk(sys_clk), .rst(rst),
        .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .queue_flags(qf), .queue_write(1'b0), .dma_active(dma),
        .divider_compat_select(1'b0), .engine_src_edge(1'b0),
        .clock_pattern_word(pat), .transmit_word_zero(tx0),
        .transmit_word_one(tx1), .receive_word_zero(rx0),
        .receive_word_one(rx1), .word_taken(taken), .word_stored(done),
        .serial_in({1'b0, 1'b1, 1'b0, miso}), .serial_out(so),
        .unit_irq(irq));
    spi_slave_model pm_u (.sys_clk(sys_clk), .sclk(so.sclk),
        .mosi(so.dout[0]), .reply(reply), .miso(miso), .got(got));

    always #12.5 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // gap cycle after each strobe so no signal is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge sys_clk);
        reg_wr <= 0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge sys_clk);
        reg_rd <= 0;
        @(posedge sys_clk);
    endtask
    task automatic summarize;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // read data checked in its one valid cycle, half periods measured
    always @(posedge sys_clk) begin
        rd_q <= reg_rd;
        cyc <= cyc + 1;
        if (rd_q)
            chk(reg_rdata, q.pop_front());
        if (so.sclk === 1'b1)
            hi <= hi + 1;
        else if (hi != 0) begin
            chk(hi, 4);
            hi <= 0;
        end
        // word loads counted, load-to-end and end-to-end spans measured
        vs <= taken ? 1 : vs + 1;
        if (taken)
            nt <= nt + 1;
        if (done) begin
            nd <= nd + 1;
            sp <= 0;
            chk(vs, want);
            if (nd == 2)
                chk(sp + 1, (2 * 3 + 16) * 4);
        end else
            sp <= sp + 1;
        if (cyc == 4000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        void'($urandom(83));
        repeat (6) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        rd(`SCS_OFFSET, 32'h0500_3004);
        rd(`DIV_OFFSET, 32'h0000_0000);
        qf <= 4'hA;
        rd(`SCS_OFFSET, 32'h0A00_3004);
        r = $urandom;
        wr(`DIV_OFFSET, r);
        rd(`DIV_OFFSET, r & `DIV_WMASK);
        rd(8'h08, 32'h0000_0000);
        $display("test done: registers");
        qf <= 4'h5;
        tx0 <= $urandom;
        tx1 <= $urandom;
        pat <= $urandom;
        wr(`DIV_OFFSET, 32'h0000_0003);
        wr(`SCS_OFFSET, 32'h0002_0044);
        wr(`SCS_OFFSET, 32'h0002_0045);
        rd(`SCS_OFFSET, 32'h0502_0045);
        while (done !== 1'b1)
            @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
        rd(`SCS_OFFSET, 32'h0503_0044);
        chk(irq, 1);
        chk(so.sclk, 0);
        chk(got, tx0[7:0]);
        chk(rx0[7:0], reply);
        wr(`SCS_OFFSET, 32'h0001_0044);
        rd(`SCS_OFFSET, 32'h0500_0044);
        chk(irq, 0);
        $display("test done: master word");
        // dma keeps the transfer going: two words with a gap of three
        dma <= 1;
        wr(`SCS_OFFSET, 32'h0002_3044);
        wr(`SCS_OFFSET, 32'h0002_3045);
        while (nt < 3)
            @(posedge sys_clk);
        dma <= 0;
        rd(`SCS_OFFSET, 32'h0503_3045);
        while (nd < 3)
            @(posedge sys_clk);
        @(posedge sys_clk);
        rd(`SCS_OFFSET, 32'h0503_3044);
        chk(nt, 3);
        chk(rx1, 0);
        chk({so.sclk_oe, so.dout[1]}, 2'b10);
        $display("test done: dma words");
        // varying clock on 16-bit words; high halves never stretched so
        // the high-time check still holds
        r = $urandom & 32'h5555_5555;
        pat <= r;
        want = 0;
        for (int i = 0; i < 32; i++)
            want += r[i] ? 16 : 4;
        wr(`DIV_OFFSET, 32'h0001_0003);
        wr(`SCS_OFFSET, 32'h0080_0084);
        wr(`SCS_OFFSET, 32'h0080_0085);
        while (nd < 4)
            @(posedge sys_clk);
        rd(`SCS_OFFSET, 32'h0581_0084);
        chk(rx0[15:0], {reply, reply});
        $display("test done: varying clock");
        summarize();
    end
endmodule

`default_nettype wire
